// ### verilog/smp_edge_src.sv
// PWM time base, edge event sources, blanking and output stage with APB registers
//
// Added by the designer: the register addresses and register access over APB.
`include "smp_defs.svh"
module smp_edge_src #(
  parameter bit FULL_OUTPUTS = 1'b1
) (
  input wire logic core_clk_i,
  input wire logic rst_b_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic pll_clk_tick_i,
  input wire logic ext_clk_pin_i,
  input wire logic event_input_pin_i,
  input wire logic [3:0] cmp_out_i,
  input wire logic [5:0] port_data_i,
  output logic [5:0] pwm_pin_o,
  output logic [15:0] timebase_counter_o
);
  // Writable masks depend on instance flavour
  localparam logic [7:0] OEN_MASK = FULL_OUTPUTS ? `SMP_MASK_OEN_FULL : `SMP_MASK_OEN_AB; // RULE_04
  localparam logic [7:0] POL_MASK = FULL_OUTPUTS ? `SMP_MASK_POL_FULL : `SMP_MASK_POL_AB; // RULE_04
  localparam logic [7:0] BLANK_LEN = 8'(`SMP_BLANK_CYC);

  smp_pkg::smp_cfg_t cfg_q;
  logic [7:0] ctrl_q;
  logic [15:0] phase_value_q, duty_value_q, period_value_q;
  smp_pkg::smp_apb_st_t apb_st_q;
  logic [31:0] prdata_q;
  logic pready_q, pslverr_q;

  // Rising edge of a qualified level
  function automatic logic [4:0] smp_rise(input logic [4:0] now, input logic [4:0] prev);
    smp_rise = now & ~prev;
  endfunction : smp_rise

  // Decode of the APB access phase
  wire apb_acc = psel_i & penable_i & (apb_st_q == smp_pkg::SMP_PH_ACC);
  wire apb_wr = apb_acc & pwrite_i;
  wire [7:0] wb = pwdata_i[7:0];
  wire hit_clk = paddr_i == `SMP_OFS_CLK;
  wire hit_oen = paddr_i == `SMP_OFS_OEN;
  wire hit_pol = paddr_i == `SMP_OFS_POL;
  wire hit_blnk = paddr_i == `SMP_OFS_BLNK;
  wire hit_rebs = paddr_i == `SMP_OFS_REBS;
  wire hit_febs = paddr_i == `SMP_OFS_FEBS;
  wire hit_phs = paddr_i == `SMP_OFS_PHS;
  wire hit_ctrl = paddr_i == `SMP_OFS_CTRL;
  wire hit_ph = paddr_i == `SMP_OFS_PHASE;
  wire hit_dc = paddr_i == `SMP_OFS_DUTY;
  wire hit_pr = paddr_i == `SMP_OFS_PERIOD;
  wire hit_st = paddr_i == `SMP_OFS_STAT;
  wire hit_any = hit_clk | hit_oen | hit_pol | hit_blnk | hit_rebs | hit_febs | hit_phs |
                 hit_ctrl | hit_ph | hit_dc | hit_pr | hit_st;

  // Status word built below
  logic [15:0] tmr_q;
  logic rblank_q, fblank_q, pwm_q;
  wire [31:0] stat_word = {13'h0000, pwm_q, fblank_q, rblank_q, tmr_q};

  // Read mux; masked fields keep unimplemented bits at zero
  wire [31:0] rd_mux =
      hit_clk ? {24'h000000, cfg_q.clk_ctrl} :
      hit_oen ? {24'h000000, cfg_q.out_en} :
      hit_pol ? {24'h000000, cfg_q.pol} :
      hit_blnk ? {24'h000000, cfg_q.blank} :
      hit_rebs ? {24'h000000, cfg_q.rise_bs} :
      hit_febs ? {24'h000000, cfg_q.fall_bs} :
      hit_phs ? {24'h000000, cfg_q.rise_src} :
      hit_ctrl ? {24'h000000, ctrl_q} :
      hit_ph ? {16'h0000, phase_value_q} :
      hit_dc ? {16'h0000, duty_value_q} :
      hit_pr ? {16'h0000, period_value_q} :
      hit_st ? stat_word : 32'h00000000; // RULE_16

  // APB phase tracker: answer one cycle into the access phase
  always_ff @(posedge core_clk_i) begin
    if (!rst_b_i) begin
      apb_st_q <= smp_pkg::SMP_PH_IDLE;
    end else begin
      case (apb_st_q)
        smp_pkg::SMP_PH_IDLE: apb_st_q <= (psel_i & ~penable_i) ? smp_pkg::SMP_PH_ACC : smp_pkg::SMP_PH_IDLE;
        smp_pkg::SMP_PH_ACC: apb_st_q <= (apb_acc & pready_q) ? smp_pkg::SMP_PH_IDLE : smp_pkg::SMP_PH_ACC;
        default: apb_st_q <= smp_pkg::SMP_PH_IDLE;
      endcase
    end
  end

  // Ready, error and read data registered so outputs come from flops
  always_ff @(posedge core_clk_i) begin
    if (!rst_b_i) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h00000000;
    end else begin
      pready_q <= apb_acc & ~pready_q;
      pslverr_q <= apb_acc & ~pready_q & ~hit_any;
      prdata_q <= (apb_acc & ~pready_q & ~pwrite_i) ? rd_mux : 32'h00000000;
    end
  end

  // Write strobe only at the completing edge
  wire wr_take = apb_wr & pready_q;

  // Configuration registers, all zero after reset
  always_ff @(posedge core_clk_i) begin
    if (!rst_b_i) begin
      cfg_q <= '0; // RULE_16
      ctrl_q <= `SMP_RST8;
      phase_value_q <= `SMP_RST16;
      duty_value_q <= `SMP_RST16;
      period_value_q <= `SMP_RST16;
    end else if (wr_take) begin
      if (hit_clk) cfg_q.clk_ctrl <= wb & `SMP_MASK_CLK;
      if (hit_oen) cfg_q.out_en <= wb & OEN_MASK; // RULE_04
      if (hit_pol) cfg_q.pol <= wb & POL_MASK; // RULE_04
      if (hit_blnk) cfg_q.blank <= wb & `SMP_MASK_BLNK;
      if (hit_rebs) cfg_q.rise_bs <= wb & `SMP_MASK_BS; // RULE_10
      if (hit_febs) cfg_q.fall_bs <= wb & `SMP_MASK_BS; // RULE_11
      if (hit_phs) cfg_q.rise_src <= wb & `SMP_MASK_PHS;
      if (hit_ctrl) ctrl_q <= wb & `SMP_MASK_CTRL;
      if (hit_ph) phase_value_q <= pwdata_i[15:0];
      if (hit_dc) duty_value_q <= pwdata_i[15:0];
      if (hit_pr) period_value_q <= pwdata_i[15:0];
    end
  end

  // Two-flop synchronisers for pin, comparators and clock sources
  logic [6:0] sync1_q, sync2_q;
  always_ff @(posedge core_clk_i) begin
    if (!rst_b_i) begin
      sync1_q <= 7'h00;
      sync2_q <= 7'h00;
    end else begin
      sync1_q <= {pll_clk_tick_i, ext_clk_pin_i, event_input_pin_i, cmp_out_i}; // RULE_21
      sync2_q <= sync1_q; // RULE_21
    end
  end
  wire pin_s = sync2_q[4];
  wire [3:0] cmp_s = sync2_q[3:0];
  wire ext_s = sync2_q[5];
  wire pll_s = sync2_q[6];

  // Clock source edge detect; the source runs as a tick into core_clk, so its rate is capped at half
  logic ext_d_q, pll_d_q;
  always_ff @(posedge core_clk_i) begin
    if (!rst_b_i) begin
      ext_d_q <= 1'b0;
      pll_d_q <= 1'b0;
    end else begin
      ext_d_q <= ext_s;
      pll_d_q <= pll_s;
    end
  end
  wire [1:0] src_sel = cfg_q.clk_ctrl[`SMP_SRC_HI:`SMP_SRC_LO];
  wire src_tick = (src_sel == `SMP_SRC_FOSC) ? 1'b1 :
                  (src_sel == `SMP_SRC_PLL) ? (pll_s & ~pll_d_q) :
                  (src_sel == `SMP_SRC_PIN) ? (ext_s & ~ext_d_q) : 1'b0; // RULE_02

  // Prescaler: divide by 1, 2, 4 or 8
  logic [2:0] pre_q;
  wire [1:0] pre_sel = cfg_q.clk_ctrl[`SMP_PRE_LO:`SMP_PRE_HI];
  wire [2:0] pre_lim = 3'((4'h1 << pre_sel) - 4'h1); // RULE_01
  wire enabled = ctrl_q[`SMP_EN_BIT];
  wire tb_tick = enabled & src_tick & (pre_q == pre_lim); // RULE_19
  always_ff @(posedge core_clk_i) begin
    if (!rst_b_i || !enabled) begin
      pre_q <= 3'h0;
    end else if (src_tick) begin
      pre_q <= (pre_q == pre_lim) ? 3'h0 : 3'(pre_q + 3'h1); // RULE_01
    end
  end

  // Qualified sources: pin with its polarity, comparators as they are
  wire pin_true = pin_s ^ cfg_q.pol[`SMP_POLIN_BIT]; // RULE_05
  logic [4:0] src_prev_q;
  wire [4:0] src_now = {pin_true, cmp_s};
  wire [4:0] src_rise = smp_rise(src_now, src_prev_q);
  always_ff @(posedge core_clk_i) begin
    if (!rst_b_i) begin
      src_prev_q <= 5'h00;
    end else begin
      src_prev_q <= src_now;
    end
  end

  // Blanking masks: pin bit 7, comparators bits 4:1
  wire [4:0] rb_sel = {cfg_q.rise_bs[`SMP_PIN_BIT], cfg_q.rise_bs[`SMP_CMP_HI:`SMP_CMP_LO]}; // RULE_09
  wire [4:0] fb_sel = {cfg_q.fall_bs[`SMP_PIN_BIT], cfg_q.fall_bs[`SMP_CMP_HI:`SMP_CMP_LO]}; // RULE_11
  wire [4:0] blank_mask = (rblank_q ? rb_sel : 5'h00) | (fblank_q ? fb_sel : 5'h00); // RULE_09 RULE_10
  wire [4:0] src_ok = src_rise & ~blank_mask;

  // Rising event: any enabled source, ORed
  wire [4:0] ph_sel = {cfg_q.rise_src[`SMP_PIN_BIT], cfg_q.rise_src[`SMP_CMP_HI:`SMP_CMP_LO]};
  wire tb_phase = cfg_q.rise_src[`SMP_TB_BIT] & tb_tick & (tmr_q == phase_value_q); // RULE_14
  wire rise_evt = enabled & (|(src_ok & ph_sel) | tb_phase); // RULE_12 RULE_13 RULE_15
  wire fall_evt = enabled & tb_tick & (tmr_q == duty_value_q); // RULE_17
  wire per_evt = tb_tick & (tmr_q == period_value_q); // RULE_18

  // Time-base counter, cleared by the period match
  always_ff @(posedge core_clk_i) begin
    if (!rst_b_i || !enabled) begin
      tmr_q <= `SMP_RST16; // RULE_19
    end else if (per_evt) begin
      tmr_q <= `SMP_RST16; // RULE_18
    end else if (tb_tick) begin
      tmr_q <= 16'(tmr_q + 16'h0001);
    end
  end

  // Blanking windows opened at rising and falling events whose blank mode is immediate; fixed length trades flexibility for simplicity
  logic [7:0] rcnt_q, fcnt_q;
  wire rb_imm = cfg_q.blank[`SMP_REBM_HI:`SMP_REBM_LO] == `SMP_BLANK_IMM; // RULE_08
  wire fb_imm = cfg_q.blank[`SMP_FEBM_HI:`SMP_FEBM_LO] == `SMP_BLANK_IMM; // RULE_07
  always_ff @(posedge core_clk_i) begin
    if (!rst_b_i || !enabled) begin
      rcnt_q <= 8'h00;
      fcnt_q <= 8'h00;
    end else begin
      rcnt_q <= (rise_evt & rb_imm) ? BLANK_LEN : (rcnt_q != 8'h00) ? 8'(rcnt_q - 8'h01) : 8'h00; // RULE_20
      fcnt_q <= (fall_evt & fb_imm) ? BLANK_LEN : (fcnt_q != 8'h00) ? 8'(fcnt_q - 8'h01) : 8'h00; // RULE_20
    end
  end
  assign rblank_q = rcnt_q != 8'h00;
  assign fblank_q = fcnt_q != 8'h00;

  // PWM latch: rise sets, fall wins when both land together
  always_ff @(posedge core_clk_i) begin
    if (!rst_b_i || !enabled) begin
      pwm_q <= 1'b0;
    end else if (fall_evt) begin
      pwm_q <= 1'b0;
    end else if (rise_evt) begin
      pwm_q <= 1'b1;
    end
  end

  // Output stage: polarity then pin steering to port when disabled
  logic [5:0] pin_q;
  wire [5:0] drive = {6{pwm_q}} ^ cfg_q.pol[5:0]; // RULE_06
  wire [5:0] pin_d = (drive & cfg_q.out_en[5:0]) | (port_data_i & ~cfg_q.out_en[5:0]); // RULE_03
  always_ff @(posedge core_clk_i) begin
    if (!rst_b_i) begin
      pin_q <= 6'h00;
    end else begin
      pin_q <= pin_d;
    end
  end

  assign pwm_pin_o = pin_q;
  assign timebase_counter_o = tmr_q;
  assign prdata_o = prdata_q;
  assign pready_o = pready_q;
  assign pslverr_o = pslverr_q;
endmodule : smp_edge_src

// ### include/smp_defs.svh
// Register offsets, field positions, reset values and timing counts for the PWM edge-source front end
// Overview of operation
// [RULE_01] Prescaler field bits 5:4 divides 1/2/4/8
// [RULE_02] Source field bits 1:0 picks clock
// [RULE_03] Six enable bits hand pins to PWM
// [RULE_04] Second instance keeps only outputs A, B
// [RULE_05] Input polarity bit 6 inverts event pin
// [RULE_06] Six polarity bits make outputs active-low
// [RULE_07] Falling blank mode bits 5:4, 01 immediate
// [RULE_08] Rising blank mode bits 1:0, 01 immediate
// [RULE_09] Rise blank pin bit 7 masks pin
// [RULE_10] Rise blank bits 4:1 mask comparators
// [RULE_11] Fall blank register has same layout
// [RULE_12] Phase pin bit 7 fires rising event
// [RULE_13] Phase bits 4:1 fire on comparator rise
// [RULE_14] Phase bit 0 fires on counter match
// [RULE_15] Rising sources act in parallel, ORed
// [RULE_16] Unimplemented bits read zero, reset zero
// [RULE_17] Falling event on counter equals duty
// [RULE_18] Period match resets time-base counter
// [RULE_19] Module enable gates all operation
// [RULE_20] Immediate blanking opens window of fixed length
// [RULE_21] Pin and comparator inputs synchronised first
`ifndef SMP_DEFS_SVH
`define SMP_DEFS_SVH
`define SMP_OFS_CLK 12'h000
`define SMP_OFS_OEN 12'h004
`define SMP_OFS_POL 12'h008
`define SMP_OFS_BLNK 12'h00c
`define SMP_OFS_REBS 12'h010
`define SMP_OFS_FEBS 12'h014
`define SMP_OFS_PHS 12'h018
`define SMP_OFS_CTRL 12'h01c
`define SMP_OFS_PHASE 12'h020
`define SMP_OFS_DUTY 12'h024
`define SMP_OFS_PERIOD 12'h028
`define SMP_OFS_STAT 12'h02c
`define SMP_MASK_CLK 8'h33
`define SMP_MASK_OEN_FULL 8'h3f
`define SMP_MASK_OEN_AB 8'h03
`define SMP_MASK_POL_FULL 8'h7f
`define SMP_MASK_POL_AB 8'h43
`define SMP_MASK_BLNK 8'h33
`define SMP_MASK_BS 8'h9e
`define SMP_MASK_PHS 8'h9f
`define SMP_MASK_CTRL 8'h01
`define SMP_RST8 8'h00
`define SMP_RST16 16'h0000
`define SMP_PRE_LO 5
`define SMP_PRE_HI 4
`define SMP_SRC_HI 1
`define SMP_SRC_LO 0
`define SMP_FEBM_HI 5
`define SMP_FEBM_LO 4
`define SMP_REBM_HI 1
`define SMP_REBM_LO 0
`define SMP_POLIN_BIT 6
`define SMP_PIN_BIT 7
`define SMP_CMP_HI 4
`define SMP_CMP_LO 1
`define SMP_TB_BIT 0
`define SMP_EN_BIT 0
`define SMP_BLANK_IMM 2'h1
`define SMP_SRC_FOSC 2'h0
`define SMP_SRC_PLL 2'h1
`define SMP_SRC_PIN 2'h2
`define SMP_BLANK_NS 100
`define SMP_CLK_PERIOD_NS 10
`define SMP_BLANK_CYC ((`SMP_BLANK_NS + `SMP_CLK_PERIOD_NS - 1) / `SMP_CLK_PERIOD_NS)
`endif

// ### include/smp_pkg.sv
// Types shared by the PWM edge-source front end
package smp_pkg;
  typedef struct packed {
    logic [7:0] clk_ctrl;
    logic [7:0] out_en;
    logic [7:0] pol;
    logic [7:0] blank;
    logic [7:0] rise_bs;
    logic [7:0] fall_bs;
    logic [7:0] rise_src;
  } smp_cfg_t;
  typedef enum logic [1:0] {
    SMP_PH_IDLE = 2'b01,
    SMP_PH_ACC = 2'b10
  } smp_apb_st_t;
endpackage : smp_pkg

// ### dv/smp_chk.sv
// Port-level checks for the PWM edge-source front end
module smp_chk #(
  parameter bit FULL_OUTPUTS = 1'b1
) (
  input wire logic core_clk_i,
  input wire logic rst_b_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [31:0] prdata_o,
  input wire logic pready_o,
  input wire logic pslverr_o,
  input wire logic [5:0] port_data_i,
  input wire logic [5:0] pwm_pin_o,
  input wire logic [15:0] timebase_counter_o
);
  logic [5:0] oen_q;
  logic en_q;
  wire logic wr_ok = psel_i && penable_i && pready_o && pwrite_i;
  // Shadow copies of the enables, so pin and timer checks know the mode
  always_ff @(posedge core_clk_i) begin
    if (!rst_b_i) begin
      oen_q <= 6'h0;
      en_q <= 1'b0;
    end else if (wr_ok && paddr_i == 12'h004) begin
      oen_q <= pwdata_i[5:0] & (FULL_OUTPUTS ? 6'h3f : 6'h03);
    end else if (wr_ok && paddr_i == 12'h01c) begin
      en_q <= pwdata_i[0];
    end
  end
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rst_b_i);
  sequence seq_setup;
    psel_i && !penable_i;
  endsequence
  sequence seq_access;
    psel_i && penable_i;
  endsequence
  chk_ready_timing: assert property (seq_setup ##1 seq_access |-> !pready_o ##1 pready_o)
    else $error("pready not in second access cycle");
  chk_ready_single: assert property (pready_o |=> !pready_o)
    else $error("pready longer than one cycle");
  chk_err_unmapped: assert property (pready_o && paddr_i > 12'h02c |-> pslverr_o)
    else $error("unmapped access without error");
  chk_err_mapped: assert property (pready_o && paddr_i <= 12'h02c && paddr_i[1:0] == 2'h0 |-> !pslverr_o)
    else $error("error on mapped access");
  chk_rdata_quiet: assert property (!(pready_o && !pwrite_i) |-> prdata_o == 32'h0)
    else $error("read data outside a read answer");
  chk_unimpl_zero: assert property (pready_o && !pwrite_i && (paddr_i == 12'h000 || paddr_i == 12'h00c)
    |-> (prdata_o & 32'hffffffcc) == 32'h0)
    else $error("unimplemented bits read as one");
  chk_reset_quiet: assert property (disable iff (1'b0) !rst_b_i |=> pwm_pin_o == 6'h0 && timebase_counter_o == 16'h0)
    else $error("outputs not cleared by reset");
  chk_pins_follow: assert property ($past(rst_b_i) |->
    ((pwm_pin_o ^ $past(port_data_i)) & ~oen_q & ~$past(oen_q)) == 6'h0)
    else $error("disabled pin does not follow port");
  chk_timer_gated: assert property (!en_q && !$past(en_q) && $past(rst_b_i) |-> timebase_counter_o == 16'h0)
    else $error("timer runs while unit disabled");
endmodule : smp_chk
bind smp_edge_src smp_chk #(.FULL_OUTPUTS(FULL_OUTPUTS)) smp_chk_i (.core_clk_i(core_clk_i), .rst_b_i(rst_b_i),
  .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
  .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o), .port_data_i(port_data_i),
  .pwm_pin_o(pwm_pin_o), .timebase_counter_o(timebase_counter_o));

// ### dv/smp_far_model.sv
// Far side: comparators, event pin and the two outside clock sources
module smp_far_model (
  input wire logic core_clk_i,
  output logic event_pin_o,
  output logic [3:0] cmp_o,
  output logic ext_clk_o,
  output logic pll_tick_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // Idle: pin high, comparators low
  initial begin
    event_pin_o = 1'b1;
    cmp_o = 4'h0;
    ext_clk_o = 1'b0;
    pll_tick_o = 1'b0;
  end
  // Free-running sources, unrelated in phase to the core clock
  always #7.8125 pll_tick_o = ~pll_tick_o;
  always #23 ext_clk_o = ~ext_clk_o;
  // Levels change just after a core edge
  task automatic drive(input logic pin, input logic [3:0] cmp);
    @(posedge core_clk_i);
    event_pin_o <= pin;
    cmp_o <= cmp;
  endtask : drive
endmodule : smp_far_model

// ### dv/tb.sv
// Register, time-base and event-source tests for the PWM edge-source front end
`include "smp_defs.svh"
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, err_q, evt_pin, ext_clk, pll;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, prdata, prdata2, rd_q, rd2_q;
  logic [5:0] port_q = 6'h2a, pins, pins2;
  logic [3:0] cmp;
  logic [15:0] tbc, mx;
  logic [7:0] src;
  logic [11:0] ofs [7] = '{12'h000, 12'h004, 12'h008, 12'h00c, 12'h010, 12'h014, 12'h018};
  logic [7:0] msk [7] = '{8'h33, 8'h3f, 8'h7f, 8'h33, 8'h9e, 8'h9e, 8'h9f};
  int failures = 0, comparisons = 0, g;
  always #5 core_clk_i = ~core_clk_i;
  smp_edge_src smp_edge_src_i (.core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .pll_clk_tick_i(pll), .ext_clk_pin_i(ext_clk), .event_input_pin_i(evt_pin),
    .cmp_out_i(cmp), .port_data_i(port_q), .pwm_pin_o(pins), .timebase_counter_o(tbc));
  // Two-output variant on the same bus, answering in lockstep
  smp_edge_src #(.FULL_OUTPUTS(1'b0)) smp_edge_src_ab_i (.core_clk_i(core_clk_i), .rst_b_i(rst_b_i),
    .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
    .prdata_o(prdata2), .pready_o(), .pslverr_o(), .pll_clk_tick_i(pll), .ext_clk_pin_i(ext_clk),
    .event_input_pin_i(evt_pin), .cmp_out_i(cmp), .port_data_i(port_q), .pwm_pin_o(pins2),
    .timebase_counter_o());
  smp_far_model smp_far_model_i (.core_clk_i(core_clk_i), .event_pin_o(evt_pin), .cmp_o(cmp),
    .ext_clk_o(ext_clk), .pll_tick_o(pll));
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  // One transfer; an idle cycle after it avoids re-driving psel in one step
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk_i);
    penable <= 1'b1;
    do begin
      @(posedge core_clk_i);
      n++;
    end while (pready !== 1'b1);
    rd_q = prdata;
    rd2_q = prdata2;
    err_q = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk_i);
  endtask : apb
  // Cycles between two counter steps; 99 means it stood still
  task automatic gap(output int n);
    logic [15:0] t;
    n = 0;
    t = tbc;
    while (tbc === t && n < 99) begin
      @(posedge core_clk_i);
      n++;
    end
    t = tbc;
    n = 0;
    while (tbc === t && n < 99) begin
      @(posedge core_clk_i);
      n++;
    end
  endtask : gap
  task automatic tally_and_finish();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : tally_and_finish
  // Hang guard, well past the expected run
  initial begin
    repeat (20000) @(posedge core_clk_i);
    failures++;
    tally_and_finish();
  end
  // Main sequence
  initial begin
    repeat (16) @(posedge core_clk_i);
    rst_b_i <= 1'b1;
    // Pin register loads the port value one edge after release
    repeat (2) @(posedge core_clk_i);
    chk("pins_port", pins, port_q);
    for (int i = 0; i < 7; i++) begin
      apb(1'b0, ofs[i], 32'h0);
      chk("reset_val", rd_q, 32'h0);
      apb(1'b1, ofs[i], 32'hffffffff);
      apb(1'b0, ofs[i], 32'h0);
      chk("ones_full", rd_q, {24'h0, msk[i]});
      chk("ones_ab", rd2_q, {24'h0, i == 1 ? 8'h03 : i == 2 ? 8'h43 : msk[i]});
    end
    chk("pins_inactive", pins, 6'h3f);
    chk("pins_ab", pins2, {port_q[5:2], 2'b11});
    apb(1'b1, `SMP_OFS_POL, 32'h0);
    @(posedge core_clk_i);
    chk("pins_act_high", pins, 6'h00);
    apb(1'b0, 12'h030, 32'h0);
    chk("unmapped", {rd_q[31:1], err_q}, 32'h1);
    apb(1'b1, `SMP_OFS_PERIOD, 32'h9);
    apb(1'b1, `SMP_OFS_PHASE, 32'h2);
    apb(1'b1, `SMP_OFS_DUTY, 32'h6);
    apb(1'b1, `SMP_OFS_PHS, 32'h01);
    apb(1'b1, `SMP_OFS_CTRL, 32'h1);
    for (int c = 0; c < 4; c++) begin
      apb(1'b1, `SMP_OFS_CLK, 32'(c << 4));
      gap(g);
      chk("prescale", 32'(g), 32'(1 << c));
    end
    for (int s = 1; s < 4; s++) begin
      apb(1'b1, `SMP_OFS_CLK, 32'(s));
      gap(g);
      chk("clk_source", 32'(g < 99), 32'(s != 3));
    end
    apb(1'b1, `SMP_OFS_CLK, 32'h0);
    // Let a stale prescaler count wrap before counting high cycles
    repeat (10) @(posedge core_clk_i);
    g = 0;
    mx = 16'h0;
    repeat (100) begin
      @(posedge core_clk_i);
      g += int'(pins[0] === 1'b1);
      mx = tbc > mx ? tbc : mx;
    end
    chk("high_cycles", 32'(g), 32'd40);
    chk("timer_max", mx, 16'h9);
    apb(1'b1, `SMP_OFS_POL, 32'h40);
    apb(1'b1, `SMP_OFS_DUTY, 32'hfff0);
    apb(1'b1, `SMP_OFS_PERIOD, 32'hffff);
    for (int i = 0; i < 5; i++) begin
      src = i == 0 ? 8'h80 : 8'h01 << i;
      apb(1'b1, `SMP_OFS_CTRL, 32'h0);
      apb(1'b1, `SMP_OFS_PHS, {24'h0, ~src & 8'h9e});
      apb(1'b1, `SMP_OFS_CTRL, 32'h1);
      smp_far_model_i.drive(i != 0, src[4:1]);
      repeat (6) @(posedge core_clk_i);
      chk("evt_unselected", pins[0], 1'b0);
      smp_far_model_i.drive(1'b1, 4'h0);
      apb(1'b1, `SMP_OFS_PHS, {24'h0, src});
      smp_far_model_i.drive(i != 0, src[4:1]);
      repeat (6) @(posedge core_clk_i);
      chk("evt_selected", pins[0], 1'b1);
      smp_far_model_i.drive(1'b1, 4'h0);
    end
    tally_and_finish();
  end
endmodule : tb
